//--- iwd_pkg.sv
// package for the io port watchdog: port address, interval limits, timing
// assumes a 100 MHz system clock and a 16-bit io address bus
package iwd_pkg;
    localparam logic [15:0] iwd_port_addr = 16'h0443;
    localparam logic [7:0] iwd_min_code = 8'h01;
    localparam logic [7:0] iwd_max_code = 8'h3e;
    localparam int iwd_clk_hz = 100000000;
    localparam int iwd_tick_s = 1;
    // cycles in one second tick
    localparam int iwd_tick_cycles = iwd_clk_hz * iwd_tick_s;
    localparam logic [7:0] iwd_rst_pulse = 8'h10;
    typedef enum logic [1:0] {
        iwd_off = 2'b00,
        iwd_run = 2'b01,
        iwd_fire = 2'b11
    } iwd_state_t;
endpackage

//--- iwd_tick_if.sv
// interface carrying the one second tick between divider and watchdog
// assumes one clock domain shared by both ends
`timescale 1ns/1ps
interface iwd_tick_if;
    logic restart;
    logic tick;
    modport divider (input restart, output tick);
    modport user (output restart, input tick);
endinterface

//--- iwd_tick_div.sv
// divider making a one-cycle pulse each tick period
// assumes restart is from logic on the same clock
`timescale 1ns/1ps
module iwd_tick_div #(
    parameter int tick_cycles = iwd_pkg::iwd_tick_cycles
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // tick carrier
    iwd_tick_if.divider t
);
    typedef struct packed {
        logic [31:0] cnt;
        logic tick;
    } iwd_div_t;
    iwd_div_t s, next_s;
    // count down and pulse at wrap; restart aligns the second
    always_comb begin
        next_s = s;
        next_s.tick = 1'b0;
        if (t.restart || s.cnt == 32'h0) begin
            next_s.cnt = 32'(tick_cycles - 1);
        end else begin
            next_s.cnt = s.cnt - 32'h1;
        end
        if (!t.restart && s.cnt == 32'h0) begin
            next_s.tick = 1'b1;
        end
    end
    // state register
    always_ff @(posedge clk) begin
        if (reset) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end
    assign t.tick = s.tick;
endmodule

//--- iwd_top.sv
// io port watchdog timer: one byte port, write starts, read stops
// assumes io strobes are one-cycle pulses synchronous to clk
`timescale 1ns/1ps
module iwd_top #(
    parameter int tick_cycles = iwd_pkg::iwd_tick_cycles
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // io port access
    input wire logic [15:0] io_addr,
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic [7:0] io_wdata,
    output logic [7:0] io_rdata,
    // configuration: 1 selects interrupt, 0 selects processor reset
    input wire logic use_irq,
    // timeout actions
    output logic cpu_reset,
    output logic irq,
    // status
    output logic running
);
    typedef struct packed {
        iwd_pkg::iwd_state_t st;
        logic [7:0] code;
        logic [7:0] left;
        logic [7:0] pulse;
        logic [7:0] rdata;
        logic rst_out;
        logic irq_out;
    } iwd_reg_t;
    iwd_reg_t s, next_s;
    logic hit, wr_hit, rd_hit;
    logic [7:0] code_in;
    iwd_tick_if tk ();
    iwd_tick_div #(.tick_cycles(tick_cycles)) u_div (
        .clk(clk),
        .reset(reset),
        .t(tk)
    );
    // port decode
    assign hit = (io_addr == iwd_pkg::iwd_port_addr);
    assign wr_hit = hit && io_wr;
    assign rd_hit = hit && io_rd && !io_wr;
    // out of range codes are clamped into the legal span
    always_comb begin
        code_in = io_wdata;
        if (io_wdata < iwd_pkg::iwd_min_code) begin
            code_in = iwd_pkg::iwd_min_code;
        end else if (io_wdata > iwd_pkg::iwd_max_code) begin
            code_in = iwd_pkg::iwd_max_code;
        end
    end
    assign tk.restart = wr_hit;
    // watchdog state machine
    always_comb begin
        next_s = s;
        next_s.irq_out = 1'b0;
        if (rd_hit) begin
            next_s.rdata = s.code;
        end
        case (s.st)
            iwd_pkg::iwd_off: begin
                if (wr_hit) begin
                    next_s.code = code_in;
                    next_s.left = code_in;
                    next_s.st = iwd_pkg::iwd_run;
                end
            end
            iwd_pkg::iwd_run: begin
                if (rd_hit) begin
                    next_s.st = iwd_pkg::iwd_off;
                end else if (wr_hit) begin
                    next_s.code = code_in;
                    next_s.left = code_in;
                end else if (tk.tick) begin
                    next_s.left = s.left - 8'h01;
                    if (s.left == 8'h01) begin
                        // interrupt mode drops straight back to off so
                        // a handler can rearm at once
                        next_s.irq_out = use_irq;
                        if (use_irq) begin
                            next_s.st = iwd_pkg::iwd_off;
                        end else begin
                            next_s.st = iwd_pkg::iwd_fire;
                            next_s.pulse = iwd_pkg::iwd_rst_pulse;
                            next_s.rst_out = 1'b1;
                        end
                    end
                end
            end
            iwd_pkg::iwd_fire: begin
                // hold reset for a short pulse, then stay off;
                // writes are dropped while the processor is held
                if (s.pulse == 8'h00) begin
                    next_s.rst_out = 1'b0;
                    next_s.st = iwd_pkg::iwd_off;
                end else begin
                    next_s.pulse = s.pulse - 8'h01;
                end
            end
            default: begin
                next_s.st = iwd_pkg::iwd_off;
            end
        endcase
    end
    // state register; off after reset
    always_ff @(posedge clk) begin
        if (reset) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end
    assign io_rdata = s.rdata;
    assign cpu_reset = s.rst_out;
    assign irq = s.irq_out;
    assign running = (s.st == iwd_pkg::iwd_run);

    // helper: cycles the processor reset has been held so far
    logic [7:0] rst_len;
    always_ff @(posedge clk) begin
        if (reset) begin
            rst_len <= 8'h00;
        end else if (cpu_reset) begin
            rst_len <= rst_len + 8'h01;
        end else begin
            rst_len <= 8'h00;
        end
    end

    // timeout fires only after the down-count hits one on a tick
    fire_cause_a: assert property (@(posedge clk)
        disable iff (reset)
        (s.st == iwd_pkg::iwd_run && (next_s.rst_out || next_s.irq_out))
        |-> (tk.tick && s.left == 8'h01 && !wr_hit && !rd_hit))
        else $error("timeout without expiry");
    // a read while running stops the watchdog next cycle
    read_stop_a: assert property (@(posedge clk)
        disable iff (reset)
        (rd_hit && s.st == iwd_pkg::iwd_run) |=> !running)
        else $error("read did not disable");
    // a read returns the last loaded code on the next cycle
    read_data_a: assert property (@(posedge clk)
        disable iff (reset)
        rd_hit |=> (io_rdata == $past(s.code)))
        else $error("read data not the loaded code");
    // a write while off starts it with the clamped code
    write_start_a: assert property (@(posedge clk)
        disable iff (reset)
        (wr_hit && s.st == iwd_pkg::iwd_off) |=>
        (running && s.left == $past(code_in)))
        else $error("write did not start");
    // a refresh reloads the count
    refresh_load_a: assert property (@(posedge clk)
        disable iff (reset)
        (wr_hit && running) |=> (running && s.left == $past(code_in)))
        else $error("refresh did not reload");
    // the loaded code only changes on a write
    code_hold_a: assert property (@(posedge clk)
        disable iff (reset)
        !wr_hit |=> (s.code == $past(s.code)))
        else $error("code changed without a write");
    // each tick without access takes one second off the count
    tick_step_a: assert property (@(posedge clk)
        disable iff (reset)
        (running && tk.tick && !wr_hit && !rd_hit && s.left != 8'h01)
        |=> (running && s.left == $past(s.left) - 8'h01))
        else $error("count did not step");
    // the remaining count stays in range while running
    code_range_a: assert property (@(posedge clk)
        disable iff (reset)
        running |-> (s.left >= iwd_pkg::iwd_min_code &&
        s.left <= iwd_pkg::iwd_max_code))
        else $error("count out of range");
    // interrupt mode never resets the processor
    irq_mode_a: assert property (@(posedge clk)
        disable iff (reset)
        $rose(cpu_reset) |-> !$past(use_irq))
        else $error("reset in interrupt mode");
    // reset mode never raises the interrupt
    rst_mode_a: assert property (@(posedge clk)
        disable iff (reset)
        $rose(irq) |-> $past(use_irq))
        else $error("interrupt in reset mode");
    // interrupt is a single pulse
    irq_pulse_a: assert property (@(posedge clk)
        disable iff (reset)
        irq |=> !irq)
        else $error("irq longer than a cycle");
    // processor reset held for at least 8 cycles
    rst_hold_a: assert property (@(posedge clk)
        disable iff (reset)
        $rose(cpu_reset) |-> cpu_reset [*8])
        else $error("reset pulse too short");
    // reset pulse ends after exactly the programmed width plus one cycle
    rst_width_a: assert property (@(posedge clk)
        disable iff (reset)
        ($fell(cpu_reset) && !$past(reset)) |->
        (rst_len == iwd_pkg::iwd_rst_pulse + 8'h01))
        else $error("reset pulse width wrong");
    // the firing state always drives the processor reset
    fire_drive_a: assert property (@(posedge clk)
        disable iff (reset)
        (s.st == iwd_pkg::iwd_fire) |-> cpu_reset)
        else $error("firing without reset");
    // no action while disabled
    off_quiet_a: assert property (@(posedge clk)
        disable iff (reset)
        (s.st == iwd_pkg::iwd_off) |=> !irq)
        else $error("action while off");
    // system reset leaves the watchdog off and quiet
    reset_off_a: assert property (@(posedge clk)
        $fell(reset) |-> (!running && !cpu_reset && !irq))
        else $error("not off after reset");
    // the watchdog stays off until the next write
    off_hold_a: assert property (@(posedge clk)
        disable iff (reset)
        (s.st == iwd_pkg::iwd_off && !wr_hit) |=> !running)
        else $error("started without a write");
endmodule

//--- tb.sv
// self-checking bench for the io port watchdog, driving the io port directly
// assumes iwd_pkg and iwd_top are compiled first; tick shortened to 10 cycles
`timescale 1ns/1ps
module tb;
    localparam int tc = 10;
    localparam logic [15:0] port = iwd_pkg::iwd_port_addr;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [15:0] io_addr = 16'h0000;
    logic io_wr = 1'b0;
    logic io_rd = 1'b0;
    logic [7:0] io_wdata = 8'h00;
    logic use_irq = 1'b0;
    wire logic [7:0] io_rdata;
    wire logic cpu_reset;
    wire logic irq;
    wire logic running;
    int num_errors = 0;
    int checks = 0;
    int n;
    // 100 mhz clock
    always #5 clk = ~clk;
    // device under test with a short tick
    iwd_top #(.tick_cycles(tc)) dut (
        .clk(clk), .reset(reset), .io_addr(io_addr), .io_wr(io_wr),
        .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata),
        .use_irq(use_irq), .cpu_reset(cpu_reset), .irq(irq),
        .running(running)
    );
    // compare and report
    task automatic chk(input string what, input logic [15:0] e,
                       input logic [15:0] g);
        checks++;
        if (g !== e) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", what, e, g);
        end
    endtask
    // one io cycle; returns at the edge where it is taken
    task automatic io_cyc(input logic wr, input logic [15:0] a,
                          input logic [7:0] d);
        @(posedge clk);
        io_addr <= a;
        io_wdata <= d;
        io_wr <= wr;
        io_rd <= ~wr;
        @(posedge clk);
        io_wr <= 1'b0;
        io_rd <= 1'b0;
    endtask
    // count settled cycles until a timeout action or the limit
    task automatic wait_fire(input int lim);
        n = 0;
        while (n < lim && cpu_reset !== 1'b1 && irq !== 1'b1) begin
            @(posedge clk);
            #1;
            n++;
        end
    endtask
    // verdict and end of run
    task automatic wrap_up();
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // cut a hang short
    initial begin
        #100000;
        num_errors++;
        $display("MISMATCH run time expected done seen hang");
        wrap_up();
    end
    // test sequence
    initial begin
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        #1;
        chk("idle outputs", 16'h0, 16'({running, cpu_reset, irq}));
        io_cyc(1'b1, 16'h0442, 8'h03);
        @(posedge clk);
        #1;
        chk("other address", 16'h0, 16'(running));
        io_cyc(1'b1, port, 8'h03);
        @(posedge clk);
        #1;
        chk("running", 16'h1, 16'(running));
        wait_fire(400);
        chk("reset time", 16'h1, 16'(n >= 3*tc-1 && n <= 3*tc+2));
        chk("reset action", 16'h2, 16'({cpu_reset, irq}));
        n = 0;
        while (cpu_reset === 1'b1 && n < 40) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk("reset width", 16'(iwd_pkg::iwd_rst_pulse + 8'h01),
            16'(n));
        chk("off after fire", 16'h0, 16'(running));
        @(posedge clk);
        use_irq <= 1'b1;
        io_cyc(1'b1, port, 8'h02);
        repeat (4) begin
            wait_fire(2*tc-4);
            chk("refresh holds", 16'(2*tc-4), 16'(n));
            io_cyc(1'b1, port, 8'h02);
        end
        io_cyc(1'b0, port, 8'h00);
        @(posedge clk);
        #1;
        chk("read data", 16'h02, 16'(io_rdata));
        chk("stopped", 16'h0, 16'(running));
        wait_fire(5*tc);
        chk("no fire when off", 16'(5*tc), 16'(n));
        io_cyc(1'b1, port, 8'h01);
        wait_fire(100);
        chk("irq time", 16'h1, 16'(n >= tc-1 && n <= tc+3));
        chk("irq action", 16'h1, 16'({cpu_reset, irq}));
        @(posedge clk);
        #1;
        chk("irq pulse", 16'h0, 16'(irq));
        // a write right after the interrupt must be taken again
        io_cyc(1'b1, port, 8'h7f);
        io_cyc(1'b0, port, 8'h00);
        @(posedge clk);
        #1;
        chk("code 7f clamp", 16'h3e, 16'(io_rdata));
        io_cyc(1'b1, port, 8'h00);
        io_cyc(1'b0, port, 8'h00);
        @(posedge clk);
        #1;
        chk("code 00 clamp", 16'h01, 16'(io_rdata));
        // system reset in mid-count leaves the watchdog off
        io_cyc(1'b1, port, 8'h05);
        @(posedge clk);
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        #1;
        chk("reset stops", 16'h0, 16'(running));
        wait_fire(6*tc);
        chk("off after reset", 16'(6*tc), 16'(n));
        io_cyc(1'b1, port, 8'h3e);
        wait_fire(700);
        chk("62 s", 16'h1, 16'(n >= 62*tc-1 && n <= 62*tc+3));
        wrap_up();
    end
endmodule
